// *** spr_pkg.sv ***
package spr_pkg;
	localparam int          DATA_W      = 32;
	localparam int          ADDR_W      = 5;
	localparam int          RCNT_W      = 5;
	localparam int          STEP_W      = 12;
	localparam int          LSB_W       = 13;
	localparam int          MSB_W       = 12;
	localparam int          FINE_W      = LSB_W + MSB_W;
	localparam logic [4:0]  OFS_PROGRAM = 5'h00;
	localparam logic [4:0]  OFS_WORD0   = 5'h04;
	localparam logic [4:0]  OFS_WORD1   = 5'h08;
	localparam logic [4:0]  OFS_WORD2   = 5'h0c;
	localparam logic [4:0]  OFS_WORD7   = 5'h10;
	localparam logic [4:0]  OFS_STATUS  = 5'h14;
	localparam logic [2:0]  CODE_DIVIDE = 3'h0;
	localparam logic [2:0]  CODE_LOWFINE = 3'h1;
	localparam logic [2:0]  CODE_REFDIV = 3'h2;
	localparam logic [2:0]  CODE_DELAY  = 3'h7;
	localparam int          CTL_HI      = 2;
	localparam int          RAMP_BIT    = 31;
	localparam int          MUX_HI      = 30;
	localparam int          MUX_LO      = 27;
	localparam int          INT_HI      = 26;
	localparam int          INT_LO      = 15;
	localparam int          MSB_HI      = 14;
	localparam int          MSB_LO      = 3;
	localparam int          LSB_HI      = 27;
	localparam int          LSB_LO      = 15;
	localparam int          SLIP_BIT    = 28;
	localparam int          CP_HI       = 27;
	localparam int          CP_LO       = 24;
	localparam int          PRESC_BIT   = 22;
	localparam int          HALF_BIT    = 21;
	localparam int          DBL_BIT     = 20;
	localparam int          RCNT_HI     = 19;
	localparam int          RCNT_LO     = 15;
	localparam int          STEP_HI     = 14;
	localparam int          STEP_LO     = 3;
	localparam logic [31:0] WORD_RST    = 32'h0000_0000;
	localparam logic [3:0]  BE_ALL      = 4'hf;
	localparam logic [4:0]  RCNT_ONE    = 5'h01;
	localparam logic [11:0] STEP_ONE    = 12'h001;
	typedef struct packed {
		logic [31:0] word0;
		logic [31:0] word1;
		logic [31:0] word2;
		logic [31:0] word7;
		logic [12:0] lsb_active;
		logic        ack;
		logic [31:0] rdata;
		logic        ref_s1;
		logic        ref_s2;
		logic        ref_prev;
		logic [4:0]  rcnt;
		logic        halve;
		logic        pd_tick;
		logic [11:0] step_cnt;
		logic        step_tick;
	} spr_state_t;
endpackage

// *** spr_top.sv ***
// Decided for this implementation: the address map and register access over Avalon-MM.
`timescale 1ns/10ps
module spr_top (
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        ce_in,
	input  wire logic [4:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic      [31:0] avs_readdata_out,
	output logic             avs_waitrequest_out,
	input  wire logic        ref_clk_pin_in,
	output logic             ramp_enable_out,
	output logic      [3:0]  monitor_output_select_out,
	output logic      [11:0] int_value_out,
	output logic      [24:0] fine_divide_value_out,
	output logic             cycle_slip_reduce_out,
	output logic      [3:0]  charge_pump_code_out,
	output logic             prescaler_sel_out,
	output logic      [31:0] ramp_delay_word_out,
	output logic             phase_detector_input_out,
	output logic             ramp_step_timer_out
);
	spr_pkg::spr_state_t s_q;
	spr_pkg::spr_state_t s_d;
	logic        req;
	logic        wr_fire;
	logic [2:0]  code;
	logic        act_edge;
	logic        r_tick;
	logic        pd_now;
	logic        step_end;
	logic [4:0]  rcnt_last;
	logic [11:0] step_len;

	always_comb begin
		s_d = s_q;
		req = avs_read_in | avs_write_in;
		code = avs_writedata_in[spr_pkg::CTL_HI:0];
		wr_fire = avs_write_in & s_q.ack & ce_in & (avs_address_in == spr_pkg::OFS_PROGRAM)
			& (avs_byteenable_in == spr_pkg::BE_ALL);
		// Doubler on: any change counts, else only falling edges
		if (s_q.word2[spr_pkg::DBL_BIT]) begin
			act_edge = s_q.ref_s2 ^ s_q.ref_prev;
		end else begin
			act_edge = s_q.ref_prev & ~s_q.ref_s2;
		end
		// Field value 0 wraps to divide by 32
		rcnt_last = s_q.word2[spr_pkg::RCNT_HI:spr_pkg::RCNT_LO] - spr_pkg::RCNT_ONE;
		r_tick = act_edge & (s_q.rcnt == rcnt_last);
		if (s_q.word2[spr_pkg::HALF_BIT]) begin
			pd_now = r_tick & s_q.halve;
		end else begin
			pd_now = r_tick;
		end
		step_len = s_q.word2[spr_pkg::STEP_HI:spr_pkg::STEP_LO];
		step_end = (step_len == '0) | (s_q.step_cnt >= step_len - spr_pkg::STEP_ONE);
		if (ce_in) begin
			s_d.ack = req & ~s_q.ack;
			s_d.ref_s1 = ref_clk_pin_in;
			s_d.ref_s2 = s_q.ref_s1;
			s_d.ref_prev = s_q.ref_s2;
			if (act_edge) begin
				s_d.rcnt = r_tick ? '0 : s_q.rcnt + spr_pkg::RCNT_ONE;
			end
			if (r_tick) begin
				s_d.halve = ~s_q.halve;
			end
			s_d.pd_tick = pd_now;
			s_d.step_tick = 1'b0;
			// Step timer paced by the detector reference
			if (!s_q.word0[spr_pkg::RAMP_BIT]) begin
				s_d.step_cnt = '0;
			end else if (pd_now) begin
				s_d.step_cnt = step_end ? '0 : s_q.step_cnt + spr_pkg::STEP_ONE;
				s_d.step_tick = step_end;
			end
			if (req & ~s_q.ack) begin
				if (avs_address_in == spr_pkg::OFS_WORD0) begin
					s_d.rdata = s_q.word0;
				end else if (avs_address_in == spr_pkg::OFS_WORD1) begin
					s_d.rdata = s_q.word1;
				end else if (avs_address_in == spr_pkg::OFS_WORD2) begin
					s_d.rdata = s_q.word2;
				end else if (avs_address_in == spr_pkg::OFS_WORD7) begin
					s_d.rdata = s_q.word7;
				end else if (avs_address_in == spr_pkg::OFS_STATUS) begin
					s_d.rdata = {1'b0, s_q.step_cnt, s_q.rcnt, s_q.halve, s_q.lsb_active};
				end else begin
					s_d.rdata = spr_pkg::WORD_RST;
				end
			end
			if (wr_fire) begin
				case (code)
					spr_pkg::CODE_DIVIDE: begin
						s_d.word0 = avs_writedata_in;
						// Staged low part goes live with the upper part
						s_d.lsb_active = s_q.word1[spr_pkg::LSB_HI:spr_pkg::LSB_LO];
					end
					spr_pkg::CODE_LOWFINE: begin
						s_d.word1 = avs_writedata_in;
					end
					spr_pkg::CODE_REFDIV: begin
						s_d.word2 = avs_writedata_in;
					end
					spr_pkg::CODE_DELAY: begin
						s_d.word7 = avs_writedata_in;
					end
					default: begin
						// Other codes belong to registers not held here
						s_d.word7 = s_q.word7;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign avs_waitrequest_out = req & ~(s_q.ack & ce_in);
	assign avs_readdata_out = s_q.rdata;
	assign ramp_enable_out = s_q.word0[spr_pkg::RAMP_BIT];
	assign monitor_output_select_out = s_q.word0[spr_pkg::MUX_HI:spr_pkg::MUX_LO];
	assign int_value_out = s_q.word0[spr_pkg::INT_HI:spr_pkg::INT_LO];
	// Unsigned concatenation gives low plus upper times 8192
	assign fine_divide_value_out = {s_q.word0[spr_pkg::MSB_HI:spr_pkg::MSB_LO],
		s_q.lsb_active};
	// Duty and pump current are left to the host
	assign cycle_slip_reduce_out = s_q.word2[spr_pkg::SLIP_BIT];
	assign charge_pump_code_out = s_q.word2[spr_pkg::CP_HI:spr_pkg::CP_LO];
	assign prescaler_sel_out = s_q.word2[spr_pkg::PRESC_BIT];
	assign ramp_delay_word_out = s_q.word7;
	assign phase_detector_input_out = s_q.pd_tick;
	assign ramp_step_timer_out = s_q.step_tick;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	property p_load_divide;
		wr_fire && code == spr_pkg::CODE_DIVIDE |=> s_q.word0 == $past(avs_writedata_in);
	endproperty
	a_load_divide: assert property (p_load_divide) else $error("divide word not loaded");

	property p_load_low;
		wr_fire && code == spr_pkg::CODE_LOWFINE |=> s_q.word1 == $past(avs_writedata_in);
	endproperty
	a_load_low: assert property (p_load_low) else $error("low fine word not staged");

	property p_load_ref;
		wr_fire && code == spr_pkg::CODE_REFDIV
			|=> charge_pump_code_out == $past(avs_writedata_in[spr_pkg::CP_HI:spr_pkg::CP_LO]);
	endproperty
	a_load_ref: assert property (p_load_ref) else $error("reference word not loaded");

	property p_load_delay;
		wr_fire && code == spr_pkg::CODE_DELAY |=> ramp_delay_word_out == $past(avs_writedata_in);
	endproperty
	a_load_delay: assert property (p_load_delay) else $error("delay word not loaded");

	property p_ramp;
		wr_fire && code == spr_pkg::CODE_DIVIDE
			|=> ramp_enable_out == $past(avs_writedata_in[spr_pkg::RAMP_BIT]);
	endproperty
	a_ramp: assert property (p_ramp) else $error("ramp enable wrong");

	property p_mux_int;
		wr_fire && code == spr_pkg::CODE_DIVIDE
			|=> {monitor_output_select_out, int_value_out}
			== $past(avs_writedata_in[spr_pkg::MUX_HI:spr_pkg::INT_LO]);
	endproperty
	a_mux_int: assert property (p_mux_int) else $error("select or integer wrong");

	property p_staged_hold;
		wr_fire && code == spr_pkg::CODE_LOWFINE
			|=> fine_divide_value_out == $past(fine_divide_value_out);
	endproperty
	a_staged_hold: assert property (p_staged_hold) else $error("staged value went live");

	property p_transfer;
		wr_fire && code == spr_pkg::CODE_DIVIDE
			|=> fine_divide_value_out == {$past(avs_writedata_in[spr_pkg::MSB_HI:spr_pkg::MSB_LO]),
			$past(s_q.word1[spr_pkg::LSB_HI:spr_pkg::LSB_LO])};
	endproperty
	a_transfer: assert property (p_transfer) else $error("fine value not formed");

	property p_step_off;
		ce_in && !ramp_enable_out |=> !ramp_step_timer_out;
	endproperty
	a_step_off: assert property (p_step_off) else $error("step pulse while ramp off");

	property p_half;
		ce_in && r_tick && s_q.word2[spr_pkg::HALF_BIT] && !s_q.halve |=> !phase_detector_input_out;
	endproperty
	a_half: assert property (p_half) else $error("halving stage passed a tick");

	property p_wait;
		req && !s_q.ack |-> avs_waitrequest_out;
	endproperty
	a_wait: assert property (p_wait) else $error("request answered too early");

	property p_wait_one;
		(ce_in && req && !s_q.ack) ##1 (ce_in && req) |-> !avs_waitrequest_out;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("second request cycle still waits");

	property p_ack_drop;
		ce_in && s_q.ack |=> !s_q.ack;
	endproperty
	a_ack_drop: assert property (p_ack_drop) else $error("acknowledge held too long");

	property p_read_word0;
		ce_in && req && !s_q.ack && avs_address_in == spr_pkg::OFS_WORD0
			|=> avs_readdata_out == $past(s_q.word0);
	endproperty
	a_read_word0: assert property (p_read_word0) else $error("word0 read wrong");

	property p_read_word1;
		ce_in && req && !s_q.ack && avs_address_in == spr_pkg::OFS_WORD1
			|=> avs_readdata_out == $past(s_q.word1);
	endproperty
	a_read_word1: assert property (p_read_word1) else $error("word1 read wrong");

	property p_read_word2;
		ce_in && req && !s_q.ack && avs_address_in == spr_pkg::OFS_WORD2
			|=> avs_readdata_out == $past(s_q.word2);
	endproperty
	a_read_word2: assert property (p_read_word2) else $error("word2 read wrong");

	property p_read_word7;
		ce_in && req && !s_q.ack && avs_address_in == spr_pkg::OFS_WORD7
			|=> avs_readdata_out == $past(s_q.word7);
	endproperty
	a_read_word7: assert property (p_read_word7) else $error("word7 read wrong");

	property p_read_unmapped;
		ce_in && req && !s_q.ack && avs_address_in != spr_pkg::OFS_WORD0
			&& avs_address_in != spr_pkg::OFS_WORD1 && avs_address_in != spr_pkg::OFS_WORD2
			&& avs_address_in != spr_pkg::OFS_WORD7 && avs_address_in != spr_pkg::OFS_STATUS
			|=> avs_readdata_out == spr_pkg::WORD_RST;
	endproperty
	a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read not zero");

	property p_rdata_hold;
		!(ce_in && req && !s_q.ack) |=> $stable(avs_readdata_out);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

	property p_refuse_be;
		ce_in && avs_write_in && s_q.ack && avs_byteenable_in != spr_pkg::BE_ALL
			|=> $stable({s_q.word0, s_q.word1, s_q.word2, s_q.word7});
	endproperty
	a_refuse_be: assert property (p_refuse_be) else $error("partial write changed a word");

	property p_refuse_addr;
		ce_in && avs_write_in && s_q.ack && avs_address_in != spr_pkg::OFS_PROGRAM
			|=> $stable({s_q.word0, s_q.word1, s_q.word2, s_q.word7});
	endproperty
	a_refuse_addr: assert property (p_refuse_addr) else $error("stray write changed a word");

	property p_refuse_code;
		wr_fire && code != spr_pkg::CODE_DIVIDE && code != spr_pkg::CODE_LOWFINE
			&& code != spr_pkg::CODE_REFDIV && code != spr_pkg::CODE_DELAY
			|=> $stable({s_q.word0, s_q.word1, s_q.word2, s_q.word7, s_q.lsb_active});
	endproperty
	a_refuse_code: assert property (p_refuse_code) else $error("foreign code changed a word");

	// Clock enable low must hold every bit of state
	property p_freeze;
		!ce_in |=> $stable(s_q);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while disabled");

	property p_word0_only;
		!(wr_fire && code == spr_pkg::CODE_DIVIDE) |=> $stable(s_q.word0);
	endproperty
	a_word0_only: assert property (p_word0_only) else $error("word0 changed unasked");

	property p_word1_only;
		!(wr_fire && code == spr_pkg::CODE_LOWFINE) |=> $stable(s_q.word1);
	endproperty
	a_word1_only: assert property (p_word1_only) else $error("word1 changed unasked");

	property p_word2_only;
		!(wr_fire && code == spr_pkg::CODE_REFDIV) |=> $stable(s_q.word2);
	endproperty
	a_word2_only: assert property (p_word2_only) else $error("word2 changed unasked");

	property p_word7_only;
		!(wr_fire && code == spr_pkg::CODE_DELAY) |=> $stable(s_q.word7);
	endproperty
	a_word7_only: assert property (p_word7_only) else $error("word7 changed unasked");

	property p_lsb_only;
		!(wr_fire && code == spr_pkg::CODE_DIVIDE) |=> $stable(s_q.lsb_active);
	endproperty
	a_lsb_only: assert property (p_lsb_only) else $error("live low part moved");

	property p_slip;
		wr_fire && code == spr_pkg::CODE_REFDIV
			|=> cycle_slip_reduce_out == $past(avs_writedata_in[spr_pkg::SLIP_BIT]);
	endproperty
	a_slip: assert property (p_slip) else $error("slip enable wrong");

	property p_presc;
		wr_fire && code == spr_pkg::CODE_REFDIV
			|=> prescaler_sel_out == $past(avs_writedata_in[spr_pkg::PRESC_BIT]);
	endproperty
	a_presc: assert property (p_presc) else $error("prescaler select wrong");

	property p_mux;
		wr_fire && code == spr_pkg::CODE_DIVIDE
			|=> monitor_output_select_out == $past(avs_writedata_in[spr_pkg::MUX_HI:spr_pkg::MUX_LO]);
	endproperty
	a_mux: assert property (p_mux) else $error("monitor select wrong");

	property p_fall_only;
		ce_in && !s_q.word2[spr_pkg::DBL_BIT] && !(s_q.ref_prev && !s_q.ref_s2)
			|=> !phase_detector_input_out;
	endproperty
	a_fall_only: assert property (p_fall_only) else $error("tick without falling edge");

	property p_dbl_quiet;
		ce_in && s_q.word2[spr_pkg::DBL_BIT] && (s_q.ref_s2 == s_q.ref_prev)
			|=> !phase_detector_input_out;
	endproperty
	a_dbl_quiet: assert property (p_dbl_quiet) else $error("tick without any edge");

	property p_rcnt_count;
		ce_in && act_edge && !r_tick |=> s_q.rcnt == $past(s_q.rcnt) + spr_pkg::RCNT_ONE;
	endproperty
	a_rcnt_count: assert property (p_rcnt_count) else $error("counter missed an edge");

	property p_rcnt_wrap;
		ce_in && r_tick |=> s_q.rcnt == '0;
	endproperty
	a_rcnt_wrap: assert property (p_rcnt_wrap) else $error("counter did not wrap");

	property p_rcnt_idle;
		ce_in && !act_edge |=> $stable(s_q.rcnt);
	endproperty
	a_rcnt_idle: assert property (p_rcnt_idle) else $error("counter moved without edge");

	property p_half_pass;
		ce_in && r_tick && s_q.word2[spr_pkg::HALF_BIT] && s_q.halve
			|=> phase_detector_input_out;
	endproperty
	a_half_pass: assert property (p_half_pass) else $error("halving stage lost a tick");

	property p_direct_pass;
		ce_in && r_tick && !s_q.word2[spr_pkg::HALF_BIT]
			|=> phase_detector_input_out;
	endproperty
	a_direct_pass: assert property (p_direct_pass) else $error("counter tick lost");

	property p_halve_toggle;
		ce_in && r_tick |=> s_q.halve != $past(s_q.halve);
	endproperty
	a_halve_toggle: assert property (p_halve_toggle) else $error("halving stage stuck");

	property p_step_quiet;
		ce_in && !pd_now |=> !ramp_step_timer_out;
	endproperty
	a_step_quiet: assert property (p_step_quiet) else $error("step pulse without tick");

	property p_step_clear;
		ce_in && !ramp_enable_out |=> s_q.step_cnt == '0;
	endproperty
	a_step_clear: assert property (p_step_clear) else $error("step count kept while off");

	property p_step_short;
		ce_in && ramp_enable_out && pd_now
			&& s_q.word2[spr_pkg::STEP_HI:spr_pkg::STEP_LO] <= spr_pkg::STEP_ONE |=> ramp_step_timer_out;
	endproperty
	a_step_short: assert property (p_step_short) else $error("short step not ended");

	c_divide: cover property (wr_fire && code == spr_pkg::CODE_DIVIDE);
	c_low_then_div: cover property (wr_fire && code == spr_pkg::CODE_LOWFINE ##[1:20]
		wr_fire && code == spr_pkg::CODE_DIVIDE);
	c_pd: cover property (phase_detector_input_out);
	c_step: cover property (ramp_step_timer_out);
endmodule

// *** spr_host.sv ***
`timescale 1ns/10ps
module spr_host (
	input  wire logic        clk_in,
	input  wire logic        wait_in,
	input  wire logic [31:0] rdata_in,
	output logic      [4:0]  addr_out,
	output logic             rd_out,
	output logic             wr_out,
	output logic      [31:0] wdata_out,
	output logic      [3:0]  be_out
);
	initial begin
		addr_out = 5'h1f;
		rd_out = 1'b0;
		wr_out = 1'b0;
		wdata_out = 32'h0000_0000;
		be_out = 4'h0;
	end
	// Words come with reserved bits clear, slip only with positive polarity
	task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d,
			input logic [3:0] be, output logic [31:0] q);
		int n;
		@(posedge clk_in);
		addr_out <= a;
		wdata_out <= d;
		be_out <= be;
		wr_out <= w;
		rd_out <= !w;
		for (n = 0; n < 50; n++) begin
			@(posedge clk_in);
			if (wait_in === 1'b0)
				break;
		end
		// Accepting edge: data is taken and the request dropped here
		q = rdata_in;
		wr_out <= 1'b0;
		rd_out <= 1'b0;
		// Released lines show junk so stale data is never trusted
		wdata_out <= ~d;
		addr_out <= ~a;
		if (n == 50) begin
			synth_program_regs_tb.mismatches++;
			synth_program_regs_tb.test_done();
		end
		// Let the accepting edge settle before the caller looks at outputs
		@(negedge clk_in);
	endtask
endmodule

// *** synth_program_regs_tb.sv ***
`timescale 1ns/10ps
module synth_program_regs_tb;
	logic clk_in, rst_n_in, ce, ref_pin, rd, wr, wreq, ramp, slip, presc, pd, st;
	logic [2:0] rc;
	logic [3:0] be, mux, cp;
	logic [4:0] adr;
	logic [11:0] intv;
	logic [24:0] fine;
	logic [31:0] wd, rdat, dly, q;
	int mismatches, n_checks, npd, nst;
	spr_top u_spr_top (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce),
		.avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
		.avs_writedata_in(wd), .avs_byteenable_in(be), .avs_readdata_out(rdat),
		.avs_waitrequest_out(wreq), .ref_clk_pin_in(ref_pin), .ramp_enable_out(ramp),
		.monitor_output_select_out(mux), .int_value_out(intv),
		.fine_divide_value_out(fine), .cycle_slip_reduce_out(slip),
		.charge_pump_code_out(cp), .prescaler_sel_out(presc),
		.ramp_delay_word_out(dly), .phase_detector_input_out(pd),
		.ramp_step_timer_out(st));
	spr_host u_spr_host (.clk_in(clk_in), .wait_in(wreq), .rdata_in(rdat),
		.addr_out(adr), .rd_out(rd), .wr_out(wr), .wdata_out(wd), .be_out(be));
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	initial begin
		rc = 3'h0;
		ref_pin = 1'b0;
		ce = 1'b1;
	end
	// Reference pin at one eighth of the clock
	always @(posedge clk_in) begin
		rc <= rc + 3'h1;
		ref_pin <= rc[2];
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk_rng(input int g, input int lo, input int hi);
		n_checks++;
		if (g < lo || g > hi) begin
			mismatches++;
			$display("wrong value at %0t: count %0d not in %0d..%0d", $time, g, lo, hi);
		end
	endtask
	task automatic wr_word(input logic [31:0] d);
		u_spr_host.xfer(1'b1, spr_pkg::OFS_PROGRAM, d, spr_pkg::BE_ALL, q);
	endtask
	// Count detector and step pulses over 24 reference periods
	task automatic meas();
		npd = 0;
		nst = 0;
		repeat (192) begin
			@(negedge clk_in);
			if (pd === 1'b1)
				npd++;
			if (st === 1'b1)
				nst++;
		end
	endtask
	task automatic t_divide();
		wr_word({1'b1, 4'ha, 12'h5a5, 12'h3c3, 3'h0});
		chk(ramp, 1'b1);
		chk(mux, 4'ha);
		chk(intv, 12'h5a5);
		chk(fine, {12'h3c3, 13'h0000});
		wr_word({1'b0, 4'h5, 12'h04b, 12'h3c3, 3'h0});
		chk(ramp, 1'b0);
	endtask
	task automatic t_stage();
		wr_word({4'h0, 13'h1fff, 12'h000, 3'h1});
		chk(fine, {12'h3c3, 13'h0000});
		u_spr_host.xfer(1'b0, spr_pkg::OFS_WORD1, 32'h0, 4'h0, q);
		chk(q, {4'h0, 13'h1fff, 12'h000, 3'h1});
		wr_word({1'b1, 4'h5, 12'h04b, 12'h3c3, 3'h0});
		chk(fine, {12'h3c3, 13'h1fff});
	endtask
	task automatic t_refdiv();
		// Divide by 3, step of 2 ticks, no doubler or halving
		wr_word({3'h0, 1'b0, 4'h9, 1'b0, 1'b1, 2'b00, 5'h03, 12'h002, 3'h2});
		chk(slip, 1'b0);
		chk(cp, 4'h9);
		chk(presc, 1'b1);
		meas();
		chk_rng(npd, 7, 9);
		chk_rng(nst * 2, npd - 2, npd + 2);
		wr_word({3'h0, 1'b0, 4'h1, 1'b0, 1'b0, 2'b01, 5'h03, 12'h002, 3'h2});
		chk(cp, 4'h1);
		meas();
		chk_rng(npd, 15, 17);
		// Slip reduction only with halving for even duty and least pump current
		wr_word({3'h0, 1'b1, 4'h0, 1'b0, 1'b0, 2'b10, 5'h03, 12'h002, 3'h2});
		chk(slip, 1'b1);
		meas();
		chk_rng(npd, 3, 5);
	endtask
	// A pulse caught at the freeze stays high, so counts are all or none
	task automatic t_freeze();
		@(posedge clk_in);
		ce <= 1'b0;
		meas();
		chk(npd % 192, 0);
		chk(nst % 192, 0);
		@(posedge clk_in);
		ce <= 1'b1;
	endtask
	task automatic t_delay();
		wr_word({13'h0000, 4'h5, 12'h123, 3'h7});
		chk(dly, {13'h0000, 4'h5, 12'h123, 3'h7});
		// Unused code and partial byte enable both leave state alone
		wr_word({13'h0000, 4'ha, 12'h0ff, 3'h3});
		u_spr_host.xfer(1'b1, spr_pkg::OFS_PROGRAM, {29'h0, 3'h7}, 4'h3, q);
		chk(dly, {13'h0000, 4'h5, 12'h123, 3'h7});
		chk(intv, 12'h04b);
		u_spr_host.xfer(1'b0, 5'h18, 32'h0, 4'h0, q);
		chk(q, 32'h0000_0000);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		mismatches = 0;
		n_checks = 0;
		rst_n_in = 1'b0;
		repeat (20) @(posedge clk_in);
		rst_n_in <= 1'b1;
		chk(intv, 12'h000);
		chk(fine, 25'h0000000);
		t_divide();
		t_stage();
		t_refdiv();
		t_freeze();
		t_delay();
		test_done();
	end
endmodule
